/* rtl/wcs_serializer.sv */
// Waveform curve serializer: stores one record, emits it as a framed byte stream.
// Assumes an AXI4-Lite master and a byte sink with valid/ready on the same clock.
`timescale 1ns/1ps

module wcs_serializer #(
    parameter int unsigned DEPTH = 4096
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             out_valid,
    output logic [7:0]       out_data,
    output logic             out_eom,
    input  wire logic        out_ready,
    output logic             busy
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [15:0]             mem [DEPTH];
    wcs_pkg::wcs_cfg_type    ctrl_q, cfg_q;
    wcs_pkg::wcs_state_type  state_q;
    logic [12:0]             len_q, pt_q;
    logic [AW-1:0]           ptr_q;
    logic [2:0]              sub_q;
    logic [15:0]             cnt_q;
    logic [7:0]              sum_q, chk;
    logic                    start_q, done_q;
    logic                    aw_have_q, w_have_q;
    logic [7:0]              aw_addr_q;
    logic [31:0]             w_data_q, merged;
    logic [3:0]              w_strb_q;
    logic                    wr_go, step, emit, item_end, last_byte;
    logic [7:0]              cur_byte;
    logic [15:0]             pt_val;
    logic [7:0]              asc_v;
    logic [3:0]              hund, tens, ones;
    logic                    last_pt, is_hex, no_term, need_cr;
    logic [31:0]             ctrl_rd, status_rd;
    logic [15:0]             start_cnt;

    // Upper-case hex character for nibble pos (0 = least significant)
    // upper-case letters
    function automatic logic [7:0] hex_char(input logic [15:0] v, input logic [1:0] pos);
        logic [3:0] n;
        n = 4'(v >> {pos, 2'b00});
        hex_char = (n < 4'ha) ? wcs_pkg::CH_ZERO + 8'(n) : wcs_pkg::CH_ALPHA + 8'(n);
    endfunction

    // Byte count for a record: data bytes plus the checksum byte
    function automatic logic [15:0] byte_count(input logic [12:0] n, input logic r16);
        byte_count = (r16 ? {2'h0, n, 1'b0} : {3'h0, n}) + 16'h0001;
    endfunction

    // Strobed byte merge for register writes
    function automatic logic [31:0] strb_merge(input logic [31:0] o, input logic [31:0] n,
                                               input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            o[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
        strb_merge = o;
    endfunction

    // Register views
    assign ctrl_rd   = {25'h0, ctrl_q, 1'b0};
    assign status_rd = {cnt_q, chk, 6'h0, done_q, busy};

    // Write channel acceptance, either order, one write at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= wcs_pkg::RESP_OKAY;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0;
            w_strb_q      <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q     <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_q[7:2] > wcs_pkg::REG_STATUS[7:2])
                                ? wcs_pkg::RESP_SLVERR : wcs_pkg::RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

    // Register writes; configuration and record are frozen while a frame runs
    always_comb begin
        unique case ({aw_addr_q[7:2], 2'b00})
            wcs_pkg::REG_CTRL: merged = strb_merge(ctrl_rd, w_data_q, w_strb_q);
            wcs_pkg::REG_LEN:  merged = strb_merge({19'h0, len_q}, w_data_q, w_strb_q);
            default:           merged = strb_merge(32'h0, w_data_q, w_strb_q);
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q  <= '0;
            len_q   <= wcs_pkg::LEN_RESET;
            ptr_q   <= '0;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (wr_go && !busy) begin
                unique case ({aw_addr_q[7:2], 2'b00})
                    wcs_pkg::REG_CTRL: begin
                        ctrl_q  <= merged[wcs_pkg::CTRL_ENC +: 6];
                        start_q <= merged[wcs_pkg::CTRL_START];
                    end
                    wcs_pkg::REG_LEN:  len_q <= merged[12:0];
                    wcs_pkg::REG_PTR:  ptr_q <= merged[AW-1:0];
                    wcs_pkg::REG_DATA: ptr_q <= ptr_q + 1'b1;
                    default: ;
                endcase
            end
        end
    end

    // Record store, written through the auto-incrementing pointer
    always_ff @(posedge aclk) begin
        if (wr_go && !busy && {aw_addr_q[7:2], 2'b00} == wcs_pkg::REG_DATA) begin
            mem[ptr_q] <= {w_strb_q[1] ? w_data_q[15:8] : mem[ptr_q][15:8],
                           w_strb_q[0] ? w_data_q[7:0] : mem[ptr_q][7:0]};
        end
    end

    // Read channel, answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= wcs_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= wcs_pkg::RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'b00})
                wcs_pkg::REG_CTRL:   s_axi_rdata <= ctrl_rd;
                wcs_pkg::REG_LEN:    s_axi_rdata <= {19'h0, len_q};
                wcs_pkg::REG_PTR:    s_axi_rdata <= 32'(ptr_q);
                wcs_pkg::REG_DATA:   s_axi_rdata <= {16'h0, mem[ptr_q]};
                wcs_pkg::REG_STATUS: s_axi_rdata <= status_rd;
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= wcs_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Current point and its decimal digits (ASCII sends the 8-bit sample, or the high byte of a 16-bit one)
    assign pt_val  = mem[pt_q[AW-1:0]];
    assign asc_v   = cfg_q.res16 ? pt_val[15:8] : pt_val[7:0];
    assign hund    = 4'(asc_v / 8'd100);
    assign tens    = 4'((asc_v / 8'd10) % 8'd10);
    assign ones    = 4'(asc_v % 8'd10);
    assign last_pt = (pt_q == len_q - 13'h1);
    assign is_hex  = (cfg_q.enc == wcs_pkg::ENC_HEX);
    assign chk     = 8'h00 - sum_q;
    assign no_term = !cfg_q.serial && cfg_q.term == wcs_pkg::TERM_EOM_ONLY;
    assign need_cr = cfg_q.term == wcs_pkg::TERM_CRLF;

    // Byte selection per frame section
    always_comb begin
        cur_byte = 8'h00;
        emit     = 1'b1;
        item_end = 1'b0;
        unique case (state_q)
            wcs_pkg::ST_IDLE: emit = 1'b0;
            wcs_pkg::ST_HDR: begin
                cur_byte = wcs_pkg::KEYWORD[6'(47 - 8 * sub_q) -: 8];
                item_end = (sub_q == wcs_pkg::KEY_LAST);
            end
            wcs_pkg::ST_MARK: begin
                cur_byte = !is_hex ? wcs_pkg::CH_PCT
                         : (sub_q == 3'h0) ? wcs_pkg::CH_HASH : wcs_pkg::CH_H;
                item_end = !is_hex || sub_q == 3'h1;
            end
            wcs_pkg::ST_CNT: begin
                cur_byte = is_hex ? hex_char(cnt_q, 2'(3 - sub_q))
                         : (sub_q == 3'h0) ? cnt_q[15:8] : cnt_q[7:0];
                item_end = sub_q == (is_hex ? 3'h3 : 3'h1);
            end
            wcs_pkg::ST_DATA: begin
                unique case (cfg_q.enc)
                    wcs_pkg::ENC_HEX: begin
                        cur_byte = cfg_q.res16 ? hex_char(pt_val, 2'(3 - sub_q))
                                 : hex_char({8'h0, pt_val[7:0]}, 2'(1 - sub_q));
                        item_end = sub_q == (cfg_q.res16 ? 3'h3 : 3'h1);
                    end
                    wcs_pkg::ENC_ASC: begin
                        unique case (sub_q)
                            3'h0: begin
                                cur_byte = wcs_pkg::CH_ZERO + 8'(hund);
                                emit     = hund != 4'h0;
                            end
                            3'h1: begin
                                cur_byte = wcs_pkg::CH_ZERO + 8'(tens);
                                emit     = hund != 4'h0 || tens != 4'h0;
                            end
                            3'h2: begin
                                cur_byte = wcs_pkg::CH_ZERO + 8'(ones);
                                item_end = last_pt;
                            end
                            default: begin
                                cur_byte = wcs_pkg::CH_COMMA;
                                item_end = 1'b1;
                            end
                        endcase
                    end
                    default: begin
                        cur_byte = (cfg_q.res16 && sub_q == 3'h0) ? pt_val[15:8] : pt_val[7:0];
                        item_end = sub_q == (cfg_q.res16 ? 3'h1 : 3'h0);
                    end
                endcase
            end
            wcs_pkg::ST_CHK: begin
                cur_byte = is_hex ? hex_char({8'h0, chk}, 2'(1 - sub_q)) : chk;
                item_end = !is_hex || sub_q == 3'h1;
            end
            wcs_pkg::ST_CR: begin
                cur_byte = wcs_pkg::CH_CR;
                item_end = 1'b1;
            end
            default: begin
                cur_byte = wcs_pkg::CH_LF;
                item_end = 1'b1;
            end
        endcase
    end

    // last byte is the LF, or the final item with no terminator
    assign last_byte = item_end && (state_q == wcs_pkg::ST_LF
                     || (no_term && (state_q == wcs_pkg::ST_CHK
                     || (state_q == wcs_pkg::ST_DATA && cfg_q.enc == wcs_pkg::ENC_ASC
                     && sub_q == 3'h2))));
    // Suppressed digits advance without waiting on the sink
    assign step = state_q != wcs_pkg::ST_IDLE && (!emit || !out_valid || out_ready);

    // Frame sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= wcs_pkg::ST_IDLE;
            sub_q   <= 3'h0;
            pt_q    <= 13'h0;
            cfg_q   <= '0;
            cnt_q   <= 16'h0;
        end else if (state_q == wcs_pkg::ST_IDLE) begin
            if (start_q && len_q != 13'h0) begin
                state_q <= wcs_pkg::ST_HDR;
                sub_q   <= 3'h0;
                pt_q    <= 13'h0;
                cfg_q   <= ctrl_q;
                cnt_q   <= byte_count(len_q, ctrl_q.res16);
            end
        end else if (step) begin
            sub_q <= item_end ? 3'h0 : sub_q + 3'h1;
            if (state_q == wcs_pkg::ST_DATA && cfg_q.enc == wcs_pkg::ENC_ASC && sub_q == 3'h3) begin
                pt_q <= pt_q + 13'h1;
            end
            if (item_end) begin
                unique case (state_q)
                    wcs_pkg::ST_HDR: state_q <= (cfg_q.enc == wcs_pkg::ENC_ASC)
                                                ? wcs_pkg::ST_DATA : wcs_pkg::ST_MARK;
                    // binary frame order kept for hex
                    wcs_pkg::ST_MARK: state_q <= wcs_pkg::ST_CNT;
                    wcs_pkg::ST_CNT:  state_q <= wcs_pkg::ST_DATA;
                    wcs_pkg::ST_DATA: begin
                        if (!last_pt) begin
                            pt_q <= pt_q + 13'h1;
                        end else if (cfg_q.enc != wcs_pkg::ENC_ASC) begin
                            state_q <= wcs_pkg::ST_CHK;
                        end else begin
                            state_q <= no_term ? wcs_pkg::ST_IDLE
                                     : need_cr ? wcs_pkg::ST_CR : wcs_pkg::ST_LF;
                        end
                    end
                    wcs_pkg::ST_CHK: state_q <= no_term ? wcs_pkg::ST_IDLE
                                              : need_cr ? wcs_pkg::ST_CR : wcs_pkg::ST_LF;
                    wcs_pkg::ST_CR:  state_q <= wcs_pkg::ST_LF;
                    default:         state_q <= wcs_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // Count of the record about to start, seeds the checksum
    assign start_cnt = byte_count(len_q, ctrl_q.res16);

    // sum of count bytes then each data byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sum_q <= 8'h00;
        end else if (state_q == wcs_pkg::ST_IDLE && start_q) begin
            sum_q <= start_cnt[15:8] + start_cnt[7:0];
        end else if (step && state_q == wcs_pkg::ST_DATA && sub_q == 3'h0
                     && cfg_q.enc != wcs_pkg::ENC_ASC) begin
            sum_q <= sum_q + pt_val[7:0] + (cfg_q.res16 ? pt_val[15:8] : 8'h00);
        end
    end

    // Output byte register, busy and sticky done
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_valid <= 1'b0;
            out_data  <= 8'h00;
            out_eom   <= 1'b0;
            busy      <= 1'b0;
            done_q    <= 1'b0;
        end else begin
            if (step && emit) begin
                out_valid <= 1'b1;
                out_data  <= cur_byte;
                out_eom   <= last_byte && !cfg_q.serial;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            if (start_q && len_q != 13'h0) begin
                busy   <= 1'b1;
                done_q <= 1'b0;
            end else if (state_q == wcs_pkg::ST_IDLE && busy && (!out_valid || out_ready)) begin
                busy   <= 1'b0;
                done_q <= 1'b1;
            end
        end
    end

    sequence hex_hash_s;
        state_q == wcs_pkg::ST_MARK && is_hex && sub_q == 3'h0 && step;
    endsequence
    sequence hex_h_s;
        state_q == wcs_pkg::ST_MARK && is_hex && sub_q == 3'h1 && step;
    endsequence
    sequence cnt_leave_s;
        state_q == wcs_pkg::ST_CNT && step && item_end;
    endsequence

    hex_marker_a: assert property (@(posedge aclk) disable iff (!aresetn)
        hex_hash_s |=> out_valid && out_data == wcs_pkg::CH_HASH
        && state_q == wcs_pkg::ST_MARK && sub_q == 3'h1)
        else $error("hex marker first character not #");
    hex_h_a: assert property (@(posedge aclk) disable iff (!aresetn)
        hex_h_s |=> out_valid && out_data == wcs_pkg::CH_H)
        else $error("hex marker second character not H");
    frame_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cnt_leave_s |=> state_q == wcs_pkg::ST_DATA)
        else $error("count not followed by data");
    hex_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == wcs_pkg::ST_DATA && is_hex |-> sub_q <= (cfg_q.res16 ? 3'h3 : 3'h1))
        else $error("hex point digit group too long");
    hex_chars_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == wcs_pkg::ST_DATA && is_hex && step |=> (out_data inside {[8'h30:8'h39],
        [8'h41:8'h46]}))
        else $error("non-digit in hex data");
    count_val_a: assert property (@(posedge aclk) disable iff (!aresetn)
        busy && state_q != wcs_pkg::ST_IDLE |-> cnt_q == byte_count(len_q, cfg_q.res16))
        else $error("byte count mismatch");
    bin_msb_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == wcs_pkg::ST_DATA && cfg_q.enc == wcs_pkg::ENC_BIN && cfg_q.res16
        && sub_q == 3'h0 && step |=> out_data == $past(pt_val[15:8]))
        else $error("16-bit point not high byte first");
    no_comma_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == wcs_pkg::ST_DATA && cfg_q.enc == wcs_pkg::ENC_ASC && sub_q == 3'h3
        |-> !last_pt)
        else $error("comma after last point");
    cr_lf_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == wcs_pkg::ST_CR && step |=> state_q == wcs_pkg::ST_LF)
        else $error("CR not followed by LF");
    eom_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
        out_valid && out_eom |-> state_q == wcs_pkg::ST_IDLE)
        else $error("end marker before frame end");
    chk_val_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == wcs_pkg::ST_CHK && !is_hex && step |=> out_data == $past(chk))
        else $error("checksum byte wrong");
endmodule // wcs_serializer

/* rtl/wcs_pkg.sv */
// Constants, types and register map of the waveform curve serializer.
// Assumes one clock domain and an AXI4-Lite master on the register side.
package wcs_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_LEN    = 8'h04;
    localparam logic [7:0] REG_PTR    = 8'h08;
    localparam logic [7:0] REG_DATA   = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    // Control field positions and reset values
    localparam int unsigned CTRL_START  = 0;
    localparam int unsigned CTRL_ENC    = 1;
    localparam int unsigned CTRL_RES16  = 3;
    localparam int unsigned CTRL_SERIAL = 4;
    localparam int unsigned CTRL_TERM   = 5;
    localparam logic [12:0] LEN_RESET   = 13'h0100;
    // Status field positions
    localparam int unsigned STAT_BUSY = 0;
    localparam int unsigned STAT_DONE = 1;
    localparam int unsigned STAT_CHK  = 8;
    localparam int unsigned STAT_CNT  = 16;
    // Encodings and terminator modes
    localparam logic [1:0] ENC_BIN       = 2'h0;
    localparam logic [1:0] ENC_HEX       = 2'h1;
    localparam logic [1:0] ENC_ASC       = 2'h2;
    localparam logic [1:0] TERM_LF_EOM   = 2'h0;
    localparam logic [1:0] TERM_EOM_ONLY = 2'h1;
    localparam logic [1:0] TERM_CRLF     = 2'h2;
    // Characters
    localparam logic [47:0] KEYWORD  = 48'h435552564520;
    localparam logic [2:0]  KEY_LAST = 3'h5;
    localparam logic [7:0]  CH_PCT   = 8'h25;
    localparam logic [7:0]  CH_HASH  = 8'h23;
    localparam logic [7:0]  CH_H     = 8'h48;
    localparam logic [7:0]  CH_COMMA = 8'h2c;
    localparam logic [7:0]  CH_CR    = 8'h0d;
    localparam logic [7:0]  CH_LF    = 8'h0a;
    localparam logic [7:0]  CH_ZERO  = 8'h30;
    localparam logic [7:0]  CH_ALPHA = 8'h37;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_HDR  = 3'h1,
        ST_MARK = 3'h3,
        ST_CNT  = 3'h2,
        ST_DATA = 3'h6,
        ST_CHK  = 3'h7,
        ST_CR   = 3'h5,
        ST_LF   = 3'h4
    } wcs_state_type;

    typedef struct packed {
        logic [1:0] term;
        logic       serial;
        logic       res16;
        logic [1:0] enc;
    } wcs_cfg_type;
endpackage

/* tb/wcs_sink.sv */
// Byte sink standing in for the remote controller on the frame port.
// Assumes the serializer's valid/ready byte port on the same aclk.
`timescale 1ns/1ps
module wcs_sink (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       stall,
    input  wire logic       out_valid,
    input  wire logic [7:0] out_data,
    input  wire logic       out_eom,
    output logic            out_ready
);
    logic [8:0] q[$];
    // Every other cycle refused when stalling, so held bytes get exercised
    always_ff @(posedge aclk) begin
        out_ready <= aresetn && (stall ? !out_ready : 1'b1);
        if (out_valid && out_ready) q.push_back({out_eom, out_data});
    end
endmodule // wcs_sink

/* tb/testbench.sv */
// Self-checking bench: sets up records over AXI4-Lite, compares whole frames.
// Assumes the sink model keeps every byte taken, with its end flag.
`timescale 1ns/1ps
module testbench;
    logic        aclk, aresetn, awv, wv, bre, arv, rre, stall;
    logic [7:0]  awa, ara, od;
    logic [31:0] wd, rd_data;
    logic [1:0]  br, rr;
    logic        awr, wrdy, bv, arr, rv, ov, eom, ordy, busy;
    int          errors, tests_run;
    wcs_serializer #(.DEPTH(16)) i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd_data), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .out_valid(ov), .out_data(od), .out_eom(eom), .out_ready(ordy), .busy(busy));
    wcs_sink i_sink (.aclk(aclk), .aresetn(aresetn), .stall(stall), .out_valid(ov),
        .out_data(od), .out_eom(eom), .out_ready(ordy));
    // Verdict and exit, also reached from an expired AXI wait or a frame still busy
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic hang;
        $display("[ERR] %0t wait timed out", $time);
        errors++;
        end_of_test;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Write: address and data offered together, each dropped once taken
    // Response readies stay high once raised; each call still drives its ready high again
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit got;
        got = 1'b0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        for (int k = 0; k < 40 && !got; k++) begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            got = bv;
        end
        if (!got) hang();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit got;
        got = 1'b0;
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        for (int k = 0; k < 40 && !got; k++) begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
            got = rv;
        end
        d = rd_data;
        r = rr;
        if (!got) hang();
    endtask
    // Loads two points, starts a frame and compares every byte and end flag
    task automatic frame(input logic [6:0] c, input logic [31:0] np, input logic [15:0] p0,
                         input logic [15:0] p1, input logic [159:0] e, input int n, ei);
        wr(wcs_pkg::REG_PTR, 32'h0);
        wr(wcs_pkg::REG_DATA, {16'h0, p0});
        wr(wcs_pkg::REG_DATA, {16'h0, p1});
        wr(wcs_pkg::REG_LEN, np);
        i_sink.q.delete();
        wr(wcs_pkg::REG_CTRL, {25'h0, c});
        for (int k = 0; k < 600 && (busy || i_sink.q.size() == 0); k++) @(posedge aclk);
        if (busy) hang();
        chk(32'(i_sink.q.size()), 32'(n));
        for (int i = 0; i < n; i++) chk({23'h0, i_sink.q[i]}, {23'h0, i == ei, e[8*(n-1-i)+:8]});
    endtask
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // Reset, then five frames across encodings, widths, links and ends
    initial begin
        logic [31:0] v;
        logic [1:0]  r;
        {aresetn, awv, wv, bre, arv, rre, stall, awa, ara, wd} = '0;
        errors = 0;
        tests_run = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(wcs_pkg::REG_LEN, v, r);
        chk(v, 32'h100);
        chk({30'h0, r}, {30'h0, wcs_pkg::RESP_OKAY});
        stall <= 1'b1;
        frame({wcs_pkg::TERM_LF_EOM, 2'h0, wcs_pkg::ENC_BIN, 1'b1}, 2, 16'h05, 16'ha0,
            {"CURVE %", 8'h00, 8'h03, 8'h05, 8'ha0, 8'h58, 8'h0a}, 13, 12);
        rd(wcs_pkg::REG_STATUS, v, r);
        chk(v, 32'h00035802);
        chk({30'h0, br}, {30'h0, wcs_pkg::RESP_OKAY});
        frame({wcs_pkg::TERM_CRLF, 2'h3, wcs_pkg::ENC_HEX, 1'b1}, 1, 16'h1abc, 16'h0,
            {"CURVE #H00031ABC27", 8'h0d, 8'h0a}, 20, -1);
        frame({wcs_pkg::TERM_LF_EOM, 2'h3, wcs_pkg::ENC_BIN, 1'b1}, 1, 16'h12f0, 16'h0,
            {"CURVE %", 8'h00, 8'h03, 8'h12, 8'hf0, 8'hfb, 8'h0a}, 13, -1);
        frame({wcs_pkg::TERM_EOM_ONLY, 2'h0, wcs_pkg::ENC_ASC, 1'b1}, 2, 16'h07, 16'hc8,
            "CURVE 7,200", 11, 10);
        frame({wcs_pkg::TERM_EOM_ONLY, 2'h0, wcs_pkg::ENC_HEX, 1'b1}, 1, 16'h3e, 16'h0,
            "CURVE #H00023EC0", 16, 15);
        rd(8'h14, v, r);
        chk({30'h0, r}, {30'h0, wcs_pkg::RESP_SLVERR});
        wr(8'h14, 32'h0);
        chk({30'h0, br}, {30'h0, wcs_pkg::RESP_SLVERR});
        end_of_test;
    end
endmodule // testbench
